// ### logic/status_pkg.sv
package status_pkg;

  // module clock
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;

  // flashing lamps: full blink period in ms, toggled every half period
  localparam int unsigned BLINK_PERIOD_MS = 1000;
  localparam int unsigned BLINK_HALF_CYC  = CYC_PER_MS * BLINK_PERIOD_MS / 2;

  // idle reinitialisation of the serial ports
  localparam int unsigned REINIT_MS       = 1000;
  localparam int unsigned REINIT_CYC      = CYC_PER_MS * REINIT_MS;

  // power-up lamp cycling step
  localparam int unsigned TEST_STEP_MS    = 100;
  localparam int unsigned TEST_STEP_CYC   = CYC_PER_MS * TEST_STEP_MS;

  // station number limits
  localparam logic [7:0]  STATION_MAX_NATIVE = 8'h5A;  // 90
  localparam logic [7:0]  STATION_MAX_RTP    = 8'hF7;  // 247

  // register offsets (byte addresses)
  localparam int unsigned ADDR_W          = 4;
  localparam logic [3:0]  CFG_OFS         = 4'h0;
  localparam logic [3:0]  STAT_OFS        = 4'h4;
  localparam logic [3:0]  IRQ_STAT_OFS    = 4'h8;
  localparam logic [3:0]  IRQ_MASK_OFS    = 4'hC;

  // configuration register layout
  localparam int unsigned CFG_STATION_LSB = 0;
  localparam int unsigned CFG_ROLE_LSB    = 8;
  localparam int unsigned CFG_RTP_BIT     = 10;
  localparam logic [10:0] CFG_RST         = 11'h000;

  // interrupt status / mask bits
  localparam int unsigned IRQ_W           = 5;
  localparam int unsigned IRQ_HWFAIL      = 0;
  localparam int unsigned IRQ_INVALID     = 1;
  localparam int unsigned IRQ_LINKFAIL    = 2;
  localparam int unsigned IRQ_SERERR      = 3;
  localparam int unsigned IRQ_RESTORE     = 4;

  typedef enum logic [1:0] {
    ROLE_MASTER = 2'h0,
    ROLE_SLAVE  = 2'h1,
    ROLE_PEER   = 2'h2,
    ROLE_BAD    = 2'h3
  } role_t;

  typedef enum logic [1:0] {
    CAUSE_RAM   = 2'h0,
    CAUSE_USART = 2'h1,
    CAUSE_PROM  = 2'h2,
    CAUSE_CPU   = 2'h3
  } cause_t;

  typedef enum logic [4:0] {
    ST_TEST     = 5'h01,
    ST_RUN      = 5'h02,
    ST_INVALID  = 5'h04,
    ST_HWFAIL   = 5'h08,
    ST_LINKFAIL = 5'h10
  } state_t;

  // lamp patterns, order {health, first diag, data, second diag}
  localparam logic [3:0]  PAT_ALL_ON      = 4'hF;
  localparam logic [3:0]  PAT_RAM         = 4'h7;
  localparam logic [3:0]  PAT_USART       = 4'hB;
  localparam logic [3:0]  PAT_PROM        = 4'h3;
  localparam logic [3:0]  PAT_CPU         = 4'hD;

endpackage

// ### logic/tick_gen.sv
`timescale 1ns/1ps
module tick_gen #(
  parameter int unsigned PERIOD = 4
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic clr,
  output logic      tick
);

  localparam int unsigned W = (PERIOD > 1) ? $clog2(PERIOD) : 1;
  localparam logic [W-1:0] LAST = W'(PERIOD - 1);

  logic [W-1:0] count_r;

  assign tick = (count_r == LAST) && !clr;

  always_ff @(posedge clk_sys) begin
    if (rst || clr || count_r == LAST) begin
      count_r <= '0;
    end else begin
      count_r <= count_r + W'(1);
    end
  end

endmodule

// ### logic/module_status_indicators.sv
`timescale 1ns/1ps
// Function
// - health lamp steady after good self-check
// - flash on bad config or native slave station
// - remote protocol station zero or over 247 flashes
// - invalid setup cleared only by power-up
// - health dark on test fail or processor loss
// - switch toggle shows error-cause lamp pattern
// - hardware failure stops module until power-up
// - later processor loss darkens health and data
// - health relights when processor link returns; data too if no serial error stands
// - diag lamps cycle at power-up, then on
// - data lamp on, flashing while sending
// - data lamp dark on receive or block errors
// - data lamp relit by good session or power-up
// - master and peers start while no serial error stands; slaves never unsolicited
// - remote protocol mode forces slave operation
// - idle serial reinit once per second, reread config
module module_status_indicators
  import status_pkg::*;
#(
  parameter int unsigned BLINK_HALF = BLINK_HALF_CYC,
  parameter int unsigned REINIT_PER = REINIT_CYC,
  parameter int unsigned TEST_STEP  = TEST_STEP_CYC
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  input  wire logic              selftest_done,
  input  wire logic              selftest_fail,
  input  wire logic [1:0]        selftest_cause,
  input  wire logic              cpu_link_ok,
  input  wire logic              switch_a,
  input  wire logic              switch_b,
  input  wire logic              tx_active,
  input  wire logic              rx_parity_err,
  input  wire logic              rx_overrun_err,
  input  wire logic              rx_framing_err,
  input  wire logic              bad_header,
  input  wire logic              bad_block,
  input  wire logic              bad_control,
  input  wire logic              bad_checksum,
  input  wire logic              session_ok,
  input  wire logic              busy,
  input  wire logic              solicited,
  output logic                   health_lamp,
  output logic                   first_diag_lamp,
  output logic                   data_lamp,
  output logic                   second_diag_lamp,
  output logic                   operating,
  output logic                   tx_permit,
  output logic                   reinit_pulse,
  output logic      [7:0]        station_number,
  output logic      [1:0]        link_role,
  output logic                   remote_terminal_protocol_mode,
  output logic                   irq
);

  function automatic logic station_bad(input logic [7:0] stn, input logic rtp, input logic [1:0] role);
    logic bad;
    bad = 1'b0;
    if (rtp) begin
      bad = (stn == 8'h00) || (stn > STATION_MAX_RTP);
    end else if (role == ROLE_SLAVE) begin
      bad = (stn == 8'h00) || (stn > STATION_MAX_NATIVE);
    end
    return bad;
  endfunction
  function automatic logic [3:0] cause_pattern(input logic [1:0] cause);
    logic [3:0] pat;
    pat = PAT_CPU;
    unique case (cause)
      CAUSE_RAM:   pat = PAT_RAM;
      CAUSE_USART: pat = PAT_USART;
      CAUSE_PROM:  pat = PAT_PROM;
      CAUSE_CPU:   pat = PAT_CPU;
    endcase
    return pat;
  endfunction

  state_t            state_r;
  state_t            state_nxt;
  logic [10:0]       cfg_r;
  logic [10:0]       act_cfg_r;
  logic [1:0]        cause_r;
  logic              show_cause_r;
  logic              sw_a_r;
  logic              sw_b_r;
  logic              serial_ok_r;
  logic              blink_r;
  logic [1:0]        step_r;
  logic [3:0]        lamps_r;
  logic [3:0]        lamps_nxt;
  logic [IRQ_W-1:0]  irq_stat_r;
  logic [IRQ_W-1:0]  irq_mask_r;
  logic [IRQ_W-1:0]  irq_ev;
  logic              reinit_r;
  logic              blink_tick;
  logic              step_tick;
  logic              reinit_tick;
  logic              toggle;
  logic              serial_err;
  logic              cfg_bad;
  logic              act_rtp;
  logic [1:0]        act_role;

  // blink divider runs free so every flashing lamp shares one phase
  tick_gen #(.PERIOD(BLINK_HALF)) u_blink (
    .clk_sys (clk_sys), .rst (rst), .clr (1'b0), .tick (blink_tick)
  );
  tick_gen #(.PERIOD(TEST_STEP)) u_step (
    .clk_sys (clk_sys), .rst (rst), .clr (state_r != ST_TEST), .tick (step_tick)
  );
  // busy restarts the idle second; tx_active, errors and session ends do not
  tick_gen #(.PERIOD(REINIT_PER)) u_reinit (
    .clk_sys (clk_sys), .rst (rst), .clr (busy || state_r != ST_RUN), .tick (reinit_tick)
  );

  assign toggle     = (switch_a ^ sw_a_r) || (switch_b ^ sw_b_r);
  assign serial_err = rx_parity_err || rx_overrun_err || rx_framing_err ||
                      bad_header || bad_block || bad_control || bad_checksum;
  assign act_rtp    = act_cfg_r[CFG_RTP_BIT];
  assign act_role   = act_rtp ? ROLE_SLAVE : act_cfg_r[CFG_ROLE_LSB +: 2];
  assign cfg_bad    = (cfg_r[CFG_ROLE_LSB +: 2] == ROLE_BAD && !cfg_r[CFG_RTP_BIT]) ||
                      station_bad(cfg_r[CFG_STATION_LSB +: 8], cfg_r[CFG_RTP_BIT],
                                  cfg_r[CFG_ROLE_LSB +: 2]);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_TEST: begin
        if (selftest_done) begin
          if (selftest_fail || !cpu_link_ok) begin
            state_nxt = ST_HWFAIL;
          end else if (cfg_bad) begin
            state_nxt = ST_INVALID;
          end else begin
            state_nxt = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        if (!cpu_link_ok) begin
          state_nxt = ST_LINKFAIL;
        end
      end
      ST_LINKFAIL: begin
        if (cpu_link_ok) begin
          state_nxt = ST_RUN;
        end
      end
      ST_INVALID: state_nxt = ST_INVALID;
      ST_HWFAIL:  state_nxt = ST_HWFAIL;
      default:    state_nxt = ST_TEST;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= ST_TEST;
    end else begin
      state_r <= state_nxt;
    end
  end

  // cause held from the end of the power-up test; cpu loss there counts as major
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cause_r <= CAUSE_RAM;
    end else if (state_r == ST_TEST && selftest_done) begin
      cause_r <= selftest_fail ? selftest_cause : CAUSE_CPU;
    end
  end

  // no reset: a switch left up across reset must not read as a toggle
  always_ff @(posedge clk_sys) begin
    sw_a_r <= switch_a;
    sw_b_r <= switch_b;
  end

  // later processor loss never reaches here, so no pattern is offered for it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      show_cause_r <= 1'b0;
    end else if (state_r == ST_HWFAIL && toggle) begin
      show_cause_r <= ~show_cause_r;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      blink_r <= 1'b0;
    end else if (blink_tick) begin
      blink_r <= ~blink_r;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      step_r <= 2'h0;
    end else if (step_tick) begin
      step_r <= step_r + 2'h1;
    end
  end

  // error wins over a session end in the same cycle: the session was not clean
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      serial_ok_r <= 1'b1;
    end else if (serial_err) begin
      serial_ok_r <= 1'b0;
    end else if (session_ok) begin
      serial_ok_r <= 1'b1;
    end
  end

  always_comb begin
    lamps_nxt = 4'h0;
    unique case (state_r)
      ST_TEST:     lamps_nxt = {step_r[1], step_r[0], ~step_r[1], ~step_r[0]};
      ST_RUN:      lamps_nxt = {1'b1, 1'b1,
                                serial_ok_r && (!tx_active || blink_r), 1'b1};
      ST_INVALID:  lamps_nxt = {blink_r, 1'b1, 1'b0, 1'b1};
      ST_HWFAIL:   lamps_nxt = show_cause_r ? cause_pattern(cause_r) : 4'h0;
      ST_LINKFAIL: lamps_nxt = {1'b0, 1'b1, 1'b0, 1'b1};
      default:     lamps_nxt = 4'h0;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lamps_r <= 4'h0;
    end else begin
      lamps_r <= lamps_nxt;
    end
  end

  assign health_lamp      = lamps_r[3];
  assign first_diag_lamp  = lamps_r[2];
  assign data_lamp        = lamps_r[1];
  assign second_diag_lamp = lamps_r[0];
  assign operating        = (state_r == ST_RUN);
  // serial setup reread at test end and at each idle second
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      act_cfg_r <= CFG_RST;
    end else if ((state_r == ST_TEST && selftest_done) || reinit_tick) begin
      act_cfg_r <= cfg_r;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reinit_r <= 1'b0;
    end else begin
      reinit_r <= reinit_tick && !busy;
    end
  end

  assign reinit_pulse                  = reinit_r;
  assign station_number                = act_cfg_r[CFG_STATION_LSB +: 8];
  assign link_role                     = act_role;
  assign remote_terminal_protocol_mode = act_rtp;

  // peers on a two-station link may both open while serial_ok_r is set; slaves only answer
  assign tx_permit = operating && serial_ok_r ?
                     ((act_role == ROLE_MASTER) || (act_role == ROLE_PEER) || solicited) :
                     (operating && solicited);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_r <= CFG_RST;
    end else if (reg_wr && reg_addr == CFG_OFS) begin
      cfg_r <= reg_wdata[10:0];
    end
  end
  assign irq_ev[IRQ_HWFAIL]   = (state_r != ST_HWFAIL) && (state_nxt == ST_HWFAIL);
  assign irq_ev[IRQ_INVALID]  = (state_r != ST_INVALID) && (state_nxt == ST_INVALID);
  assign irq_ev[IRQ_LINKFAIL] = (state_r == ST_RUN) && (state_nxt == ST_LINKFAIL);
  assign irq_ev[IRQ_SERERR]   = serial_err && serial_ok_r;
  assign irq_ev[IRQ_RESTORE]  = (state_r == ST_LINKFAIL) && (state_nxt == ST_RUN);

  // a new event wins over a write-one-to-clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_stat_r <= '0;
    end else if (reg_wr && reg_addr == IRQ_STAT_OFS) begin
      irq_stat_r <= (irq_stat_r & ~reg_wdata[IRQ_W-1:0]) | irq_ev;
    end else begin
      irq_stat_r <= irq_stat_r | irq_ev;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_mask_r <= '0;
    end else if (reg_wr && reg_addr == IRQ_MASK_OFS) begin
      irq_mask_r <= reg_wdata[IRQ_W-1:0];
    end
  end
  assign irq = |(irq_stat_r & irq_mask_r);
  always_ff @(posedge clk_sys) begin
    if (rst || !reg_rd) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      unique case (reg_addr)
        CFG_OFS:      reg_rdata <= {21'h0, cfg_r};
        STAT_OFS:     reg_rdata <= {19'h0, show_cause_r, serial_ok_r, cause_r, lamps_r, state_r};
        IRQ_STAT_OFS: reg_rdata <= {27'h0, irq_stat_r};
        IRQ_MASK_OFS: reg_rdata <= {27'h0, irq_mask_r};
        default:      reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  a_run_health_lit: assert property (
    @(posedge clk_sys) disable iff (rst) (state_r == ST_RUN) |=> health_lamp)
    else $error("health lamp dark while running");
  a_invalid_flash: assert property (
    @(posedge clk_sys) disable iff (rst)
    (state_r == ST_INVALID) |=> (health_lamp == $past(blink_r)))
    else $error("health lamp not following blink in invalid setup");
  a_rtp_station_bad: assert property (
    @(posedge clk_sys) disable iff (rst)
    (state_r == ST_TEST && selftest_done && !selftest_fail && cpu_link_ok && cfg_r[CFG_RTP_BIT] &&
     (cfg_r[7:0] == 8'h00 || cfg_r[7:0] > 8'hF7)) |=> (state_r == ST_INVALID))
    else $error("bad remote station number accepted");
  a_invalid_sticky: assert property (
    @(posedge clk_sys) disable iff (rst) (state_r == ST_INVALID) |=> (state_r == ST_INVALID))
    else $error("invalid setup left without power-up");
  a_fail_dark: assert property (
    @(posedge clk_sys) disable iff (rst)
    (state_r == ST_TEST && selftest_done && selftest_fail) |=> ##1 !health_lamp)
    else $error("health lamp lit after failed test");
  a_cause_shown: assert property (
    @(posedge clk_sys) disable iff (rst)
    (state_r == ST_HWFAIL && !show_cause_r && toggle) |=> ##1
    ({health_lamp, first_diag_lamp, data_lamp, second_diag_lamp} == cause_pattern(cause_r)))
    else $error("error-cause pattern not shown after toggle");
  a_hwfail_stop: assert property (
    @(posedge clk_sys) disable iff (rst) (state_r == ST_HWFAIL) |-> !operating ##1 (state_r == ST_HWFAIL))
    else $error("module recovered from hardware failure");
  a_linkfail_dark: assert property (
    @(posedge clk_sys) disable iff (rst)
    (state_r == ST_RUN && !cpu_link_ok) |=> ##1 (!health_lamp && !data_lamp && !show_cause_r))
    else $error("lamps lit after processor link loss");
  a_link_back: assert property (
    @(posedge clk_sys) disable iff (rst)
    (state_r == ST_LINKFAIL && cpu_link_ok) |=> (state_r == ST_RUN) ##1 health_lamp)
    else $error("no relight after processor link return");
  a_serial_err_dark: assert property (
    @(posedge clk_sys) disable iff (rst)
    (state_r == ST_RUN && serial_err && cpu_link_ok) |=> ##1 !data_lamp)
    else $error("data lamp lit after serial error");
  a_slave_quiet: assert property (
    @(posedge clk_sys) disable iff (rst) (tx_permit && act_role == ROLE_SLAVE) |-> solicited)
    else $error("slave permitted unsolicited transmit");
  a_rtp_is_slave: assert property (
    @(posedge clk_sys) disable iff (rst)
    remote_terminal_protocol_mode |-> (link_role == ROLE_SLAVE) && (!tx_permit || solicited))
    else $error("remote protocol mode not slave");
  a_reinit_idle: assert property (
    @(posedge clk_sys) disable iff (rst) reinit_pulse |-> $past(!busy) && (state_r == ST_RUN || $past(state_r) == ST_RUN))
    else $error("reinit while busy");

endmodule

// ### dv/link_host_model.sv
`timescale 1ns/1ps
module link_host_model
  import status_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [1:0] link_role,
  input  wire logic       req_go,
  input  wire logic       req_end,
  input  wire logic [2:0] err_sel,
  input  wire logic       err_go,
  input  wire logic       ok_go,
  output logic      [6:0] err_bus,
  output logic            session_ok,
  output logic            solicited,
  output logic            busy
);
  // one host and one station on the line, well inside eight drops
  // host only polls a station that listens as slave
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      solicited <= 1'h0;
      busy      <= 1'h0;
    end else if (req_go && link_role == ROLE_SLAVE) begin
      solicited <= 1'h1;
      busy      <= 1'h1;
    end else if (req_end) begin
      solicited <= 1'h0;
      busy      <= 1'h0;
    end
  end

  // faults and good sessions are single-cycle events
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      err_bus    <= 7'h00;
      session_ok <= 1'h0;
    end else begin
      err_bus    <= err_go ? (7'h01 << err_sel) : 7'h00;
      session_ok <= ok_go;
    end
  end
endmodule

// ### dv/tb.sv
`timescale 1ns/1ps
module tb
  import status_pkg::*;
;
  localparam int RP = 20;
  logic        clk_sys = 1'h0;
  logic        rst = 1'h1;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'h0;
  logic        reg_rd = 1'h0;
  logic        selftest_done = 1'h0;
  logic        selftest_fail = 1'h0;
  logic [1:0]  selftest_cause = 2'h0;
  logic        cpu_link_ok = 1'h1;
  logic        switch_a = 1'h0;
  logic        switch_b = 1'h0;
  logic        tx_active = 1'h0;
  logic [3:0]  cmd = 4'h0;
  logic [2:0]  err_sel = 3'h0;
  logic [31:0] reg_rdata;
  logic        health_lamp;
  logic        first_diag_lamp;
  logic        data_lamp;
  logic        second_diag_lamp;
  logic        operating;
  logic        tx_permit;
  logic        reinit_pulse;
  logic [7:0]  station_number;
  logic [1:0]  link_role;
  logic        remote_terminal_protocol_mode;
  logic        irq;
  logic [6:0]  err_bus;
  logic        session_ok;
  logic        solicited;
  logic        busy;
  logic [3:0]  lamps;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          t;
  logic [31:0] d;
  logic [1:0]  s;
  logic [31:0] cfg_tab [10] = '{32'h305, 32'h100, 32'h15B, 32'h15A, 32'h400,
                                32'h4F8, 32'h4F7, 32'h0C8, 32'h000, 32'h205};
  logic [4:0]  st_tab [10]  = '{5'h04, 5'h04, 5'h04, 5'h02, 5'h04, 5'h04, 5'h02, 5'h02, 5'h02, 5'h02};
  logic [3:0]  pat_tab [4] = '{4'h7, 4'hB, 4'h3, 4'hD};

  assign lamps = {health_lamp, first_diag_lamp, data_lamp, second_diag_lamp};

  // short counts keep the run small
  module_status_indicators #(.BLINK_HALF(4), .REINIT_PER(RP), .TEST_STEP(3)) uut (
    .clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .selftest_done, .selftest_fail, .selftest_cause, .cpu_link_ok, .switch_a, .switch_b, .tx_active,
    .rx_parity_err (err_bus[0]), .rx_overrun_err (err_bus[1]), .rx_framing_err (err_bus[2]),
    .bad_header (err_bus[3]), .bad_block (err_bus[4]), .bad_control (err_bus[5]), .bad_checksum (err_bus[6]),
    .session_ok, .busy, .solicited, .health_lamp, .first_diag_lamp, .data_lamp, .second_diag_lamp,
    .operating, .tx_permit, .reinit_pulse, .station_number, .link_role, .remote_terminal_protocol_mode, .irq
  );

  link_host_model host (
    .clk_sys, .rst, .link_role, .req_go (cmd[2]), .req_end (cmd[3]), .err_sel, .err_go (cmd[0]),
    .ok_go (cmd[1]), .err_bus, .session_ok, .solicited, .busy
  );

  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic end_of_test();
    if (n_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h got %h", nm, e, g);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic power_up();
    @(posedge clk_sys);
    rst <= 1'h1;
    repeat (5) @(posedge clk_sys);
    rst <= 1'h0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'h1;
    @(posedge clk_sys);
    reg_wr    <= 1'h0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge clk_sys);
    reg_rd   <= 1'h0;
    #1 v = reg_rdata;
  endtask

  // far-side command: {req_end, req_go, ok_go, err_go}
  task automatic pulse(input logic [3:0] m);
    @(posedge clk_sys);
    cmd <= m;
    @(posedge clk_sys);
    cmd <= 4'h0;
  endtask

  task automatic self_test(input logic f, input logic [1:0] c);
    @(posedge clk_sys);
    selftest_done  <= 1'h1;
    selftest_fail  <= f;
    selftest_cause <= c;
    @(posedge clk_sys);
    selftest_done  <= 1'h0;
    settle(3);
  endtask

  task automatic flip(input logic w);
    @(posedge clk_sys);
    if (w)
      switch_b <= ~switch_b;
    else
      switch_a <= ~switch_a;
    settle(3);
  endtask

  // records which levels a lamp showed over n cycles
  task automatic watch(input int i, input int n, output logic [1:0] v);
    v = 2'h0;
    repeat (n) begin
      @(posedge clk_sys);
      #1 v[lamps[i]] = 1'h1;
    end
  endtask

  task automatic wait_reinit(output int c);
    c = 0;
    do begin
      @(posedge clk_sys);
      #1 c++;
    end while (reinit_pulse !== 1'h1 && c < 60);
    if (c >= 60) begin
      n_errors++;
      end_of_test();
    end
  endtask

  initial begin
    power_up();
    #1 chk("reset lamps", 32'h0, 32'(lamps));
    watch(2, 30, s);
    chk("diag cycling", 32'h3, 32'(s));
    watch(0, 30, s);
    chk("diag2 cycling", 32'h3, 32'(s));
    rd(STAT_OFS, d);
    chk("test state", 32'h1, 32'(d[4:0]));
    wr(CFG_OFS, 32'h005);
    self_test(1'h0, 2'h0);
    chk("run lamps", 32'hF, 32'(lamps));
    chk("run operating", 32'h1, 32'(operating));
    chk("master permit", 32'h1, 32'(tx_permit));
    rd(4'h1, d);
    chk("unmapped read", 32'h0, d);
    wr(STAT_OFS, 32'h0);
    rd(STAT_OFS, d);
    chk("stat read only", 32'h2, 32'(d[4:0]));
    settle(1);
    chk("rdata idle", 32'h0, reg_rdata);
    @(posedge clk_sys);
    tx_active <= 1'h1;
    watch(1, 12, s);
    chk("send blink", 32'h3, 32'(s));
    @(posedge clk_sys);
    tx_active <= 1'h0;
    settle(3);
    chk("send over", 32'h1, 32'(data_lamp));
    wr(IRQ_STAT_OFS, 32'h1F);
    for (int k = 0; k < 7; k++) begin
      @(posedge clk_sys);
      err_sel <= 3'(k);
      pulse(4'h1);
      settle(4);
      chk("error dark", 32'h0, 32'(data_lamp));
      pulse(4'h2);
      settle(4);
      chk("session relit", 32'h1, 32'(data_lamp));
    end
    rd(IRQ_STAT_OFS, d);
    chk("serial irq", 32'h1, 32'(d[3]));
    wr(IRQ_MASK_OFS, 32'h0);
    settle(1);
    chk("irq masked", 32'h0, 32'(irq));
    wr(IRQ_MASK_OFS, 32'h1F);
    settle(1);
    chk("irq unmasked", 32'h1, 32'(irq));
    wr(IRQ_STAT_OFS, 32'h1F);
    settle(1);
    chk("irq cleared", 32'h0, 32'(irq));
    wr(CFG_OFS, 32'h007);
    wait_reinit(t);
    wait_reinit(t);
    chk("reinit period", 32'(RP), 32'(t));
    settle(2);
    chk("config reread", 32'h7, 32'(station_number));
    @(posedge clk_sys);
    cpu_link_ok <= 1'h0;
    settle(3);
    chk("loss lamps", 32'h0, 32'({health_lamp, data_lamp}));
    flip(1'h0);
    chk("loss no pattern", 32'h0, 32'({health_lamp, data_lamp}));
    rd(STAT_OFS, d);
    chk("loss state", 32'h10, 32'({d[12], d[4:0]}));
    @(posedge clk_sys);
    cpu_link_ok <= 1'h1;
    settle(3);
    chk("link back", 32'h3, 32'({health_lamp, data_lamp}));
    rd(IRQ_STAT_OFS, d);
    chk("link irqs", 32'h3, 32'({d[4], d[2]}));
    // slave waits to be asked; busy holds off the idle reinit
    power_up();
    wr(CFG_OFS, 32'h10A);
    self_test(1'h0, 2'h0);
    chk("slave silent", 32'h0, 32'(tx_permit));
    pulse(4'h4);
    settle(2);
    chk("slave answers", 32'h1, 32'(tx_permit));
    t = 0;
    repeat (45) begin
      @(posedge clk_sys);
      #1 t += int'(reinit_pulse === 1'h1);
    end
    chk("busy no reinit", 32'h0, 32'(t));
    pulse(4'h8);
    settle(2);
    chk("slave done", 32'h0, 32'(tx_permit));
    for (int k = 0; k < 10; k++) begin
      power_up();
      wr(CFG_OFS, cfg_tab[k]);
      self_test(1'h0, 2'h0);
      rd(STAT_OFS, d);
      chk("setup check", 32'(st_tab[k]), 32'(d[4:0]));
      if (st_tab[k] == 5'h04) begin
        watch(3, 10, s);
        chk("invalid blink", 32'h3, 32'(s));
        wr(CFG_OFS, 32'h005);
        flip(1'h0);
        rd(STAT_OFS, d);
        chk("invalid sticks", 32'h4, 32'(d[4:0]));
      end else if (cfg_tab[k][10]) begin
        chk("remote role", 32'(ROLE_SLAVE), 32'(link_role));
        chk("remote mode", 32'h1, 32'(remote_terminal_protocol_mode));
        chk("remote quiet", 32'h0, 32'(tx_permit));
      end else begin
        chk("role permit", 32'(cfg_tab[k][9:8] != 2'h1), 32'(tx_permit));
      end
    end
    for (int c = 0; c < 4; c++) begin
      power_up();
      wr(CFG_OFS, 32'h005);
      self_test(1'h1, 2'(c));
      chk("fail health", 32'h0, 32'(health_lamp));
      chk("fail stopped", 32'h0, 32'(operating));
      flip(1'h0);
      chk("cause pattern", 32'(pat_tab[c]), 32'(lamps));
      pulse(4'h2);
      flip(1'h1);
      rd(STAT_OFS, d);
      chk("fail stays", 32'h8, 32'({d[12], d[4:0]}));
      rd(IRQ_STAT_OFS, d);
      chk("fail irq", 32'h1, 32'(d[0]));
    end
    end_of_test();
  end
endmodule
